// >>> bridge_offtime_current_chopper.sv
`timescale 1ns/1ps
`default_nettype none

module chopper_phase
  import chopper_pkg::*;
#(
  parameter int unsigned MONO_DEFAULT = MONO_MIN_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire bridge_in_t         cmd,
  input  wire logic [TIMER_W-1:0] offtime_timer,
  input  wire logic               route_to_flag,
  output logic                    enable_pull_oe,
  output logic                    overcurrent_flag,
  output gates_t                  gates,
  output logic                    chopping
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEAD_ON,
    ST_ON,
    ST_MONO,
    ST_DEAD_OFF
  } phase_t;

  phase_t             state_q;
  logic [TIMER_W-1:0] count_q;
  logic [TIMER_W-1:0] mono_len;
  logic               enabled;
  logic               trip_ok;
  logic               rectify;
  logic               dir_change;
  dir_t               dir_q;

  // Fault pull-down only affects enable when not routed to flag
  assign enabled = cmd.enable_in && (route_to_flag || !cmd.fault); // R1 R2
  assign mono_len = (offtime_timer == TIMER_RESET) ?
                    TIMER_W'(MONO_DEFAULT) : offtime_timer; // R11 R13
  // Comparator ignored during blanking and minimum on time
  assign trip_ok = cmd.sense_trip &&
                   (count_q >= TIMER_W'(BLANK_CYCLES)) &&
                   (count_q >= TIMER_W'(MIN_ON_CYCLES)); // R9 R12 R17
  // Upper switch rectifies only after dead time in the off phase
  assign rectify = (state_q == ST_MONO) &&
                   (count_q >= TIMER_W'(DEAD_CYCLES)); // R10 R14
  // Direction change restarts dead time
  assign dir_change = dir_q != dir_t'({cmd.dir_first, cmd.dir_second}); // R10

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_q <= DIR_BRAKE_LOW;
    end else begin
      dir_q <= dir_t'({cmd.dir_first, cmd.dir_second});
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      count_q <= TIMER_RESET;
    end else if (!enabled) begin
      state_q <= ST_IDLE; // R1
      count_q <= TIMER_RESET;
    end else if (dir_change) begin
      state_q <= ST_IDLE; // R10
      count_q <= TIMER_RESET;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_DEAD_ON; // R10
          count_q <= TIMER_RESET;
        end
        ST_DEAD_ON: begin
          if (count_q >= TIMER_W'(DEAD_CYCLES - 1)) begin // R10 R15
            state_q <= ST_ON;
            count_q <= TIMER_RESET;
          end else begin
            count_q <= count_q + 1'b1;
          end
        end
        ST_ON: begin
          if (trip_ok) begin
            state_q <= ST_MONO; // R6
            count_q <= TIMER_RESET;
          end else if (count_q != {TIMER_W{1'b1}}) begin
            count_q <= count_q + 1'b1;
          end
        end
        ST_MONO: begin
          if (count_q >= mono_len - 1'b1) begin // R7 R8
            state_q <= ST_DEAD_OFF;
            count_q <= TIMER_RESET;
          end else begin
            count_q <= count_q + 1'b1;
          end
        end
        ST_DEAD_OFF: begin
          if (count_q >= TIMER_W'(DEAD_CYCLES - 1)) begin // R15 R8
            state_q <= ST_ON;
            count_q <= TIMER_RESET;
          end else begin
            count_q <= count_q + 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          count_q <= TIMER_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_pull_oe   <= 1'b0;
      overcurrent_flag <= 1'b0;
    end else begin
      enable_pull_oe   <= cmd.fault && !route_to_flag; // R2
      overcurrent_flag <= cmd.fault && route_to_flag; // R3
    end
  end

  // Gate outputs from flops; diagonal chosen by direction inputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gates    <= '0;
      chopping <= 1'b0;
    end else begin
      gates    <= '0;
      chopping <= (state_q == ST_MONO) || (state_q == ST_DEAD_OFF);
      if (enabled && !dir_change &&
          state_q != ST_IDLE && state_q != ST_DEAD_ON) begin
        case (dir_t'({cmd.dir_first, cmd.dir_second})) // R16
          DIR_BRAKE_LOW: begin
            gates.low_first  <= 1'b1;
            gates.low_second <= 1'b1;
          end
          DIR_FORWARD: begin
            gates.high_second <= 1'b1;
            gates.low_first   <= (state_q == ST_ON); // R6 R7 R14
            gates.high_first  <= rectify; // R14
          end
          DIR_REVERSE: begin
            gates.high_first  <= 1'b1;
            gates.low_second  <= (state_q == ST_ON); // R6 R7 R14
            gates.high_second <= rectify; // R14
          end
          DIR_BRAKE_HIGH: begin
            gates.high_first  <= 1'b1;
            gates.high_second <= 1'b1;
          end
          default: gates <= '0;
        endcase
      end
    end
  end

endmodule // chopper_phase

// Operation
// R1 - Enable low turns off whole bridge
// R2 - Fault pulls that bridge's enable low
// R3 - Option: fault shown on separate flags
// R4 - Controller drives every input, none floating
// R5 - Two independent off-time choppers, one each
// R6 - Sense trip starts monostable, low switch off
// R7 - Low off for monostable, then conduct again
// R8 - Off interval is monostable plus dead time
// R9 - Blanking ignores comparator after low turn-on
// R10 - Dead time before any switch turns on
// R11 - Off time programmable over wide range
// R12 - Minimum on time of 1.5 us
// R13 - Short recharge still works, shorter off
// R14 - Slow decay: upper switch rectifies after dead
// R15 - Low switch back on after dead time
// R16 - Direction inputs select conducting diagonal
// R17 - Retrigger only in on phase after limits
module bridge_offtime_current_chopper
  import chopper_pkg::*;
#(
  parameter int unsigned MONO_DEFAULT = MONO_MIN_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               route_to_flag,
  input  wire logic               bridge_a_dir_first,
  input  wire logic               bridge_a_dir_second,
  input  wire logic               bridge_b_dir_first,
  input  wire logic               bridge_b_dir_second,
  input  wire logic               bridge_a_enable_in,
  input  wire logic               bridge_b_enable_in,
  input  wire logic               bridge_a_sense_trip,
  input  wire logic               bridge_b_sense_trip,
  input  wire logic               bridge_a_overcurrent,
  input  wire logic               bridge_b_overcurrent,
  input  wire logic               over_temperature,
  input  wire logic [TIMER_W-1:0] bridge_a_offtime_timer,
  input  wire logic [TIMER_W-1:0] bridge_b_offtime_timer,
  output logic                    bridge_a_enable_out,
  output logic                    bridge_a_enable_oe,
  output logic                    bridge_b_enable_out,
  output logic                    bridge_b_enable_oe,
  output logic                    bridge_a_overcurrent_flag,
  output logic                    bridge_b_overcurrent_flag,
  output gates_t                  bridge_a_gates,
  output gates_t                  bridge_b_gates,
  output logic                    bridge_a_chopping,
  output logic                    bridge_b_chopping
);

  bridge_in_t cmd_a;
  bridge_in_t cmd_b;

  // Independent controller per bridge
  assign cmd_a = '{dir_first: bridge_a_dir_first,
                   dir_second: bridge_a_dir_second,
                   enable_in: bridge_a_enable_in,
                   sense_trip: bridge_a_sense_trip,
                   fault: bridge_a_overcurrent || over_temperature}; // R2
  assign cmd_b = '{dir_first: bridge_b_dir_first,
                   dir_second: bridge_b_dir_second,
                   enable_in: bridge_b_enable_in,
                   sense_trip: bridge_b_sense_trip,
                   fault: bridge_b_overcurrent || over_temperature}; // R2

  assign bridge_a_enable_out = 1'b0;
  assign bridge_b_enable_out = 1'b0;

  chopper_phase #(.MONO_DEFAULT(MONO_DEFAULT)) u_phase_a ( // R5
    .clock            (clock),
    .rst              (rst),
    .cmd              (cmd_a),
    .offtime_timer    (bridge_a_offtime_timer),
    .route_to_flag    (route_to_flag),
    .enable_pull_oe   (bridge_a_enable_oe),
    .overcurrent_flag (bridge_a_overcurrent_flag),
    .gates            (bridge_a_gates),
    .chopping         (bridge_a_chopping)
  );

  chopper_phase #(.MONO_DEFAULT(MONO_DEFAULT)) u_phase_b ( // R5
    .clock            (clock),
    .rst              (rst),
    .cmd              (cmd_b),
    .offtime_timer    (bridge_b_offtime_timer),
    .route_to_flag    (route_to_flag),
    .enable_pull_oe   (bridge_b_enable_oe),
    .overcurrent_flag (bridge_b_overcurrent_flag),
    .gates            (bridge_b_gates),
    .chopping         (bridge_b_chopping)
  );

endmodule // bridge_offtime_current_chopper

`default_nettype wire

// >>> chopper_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module chopper_monitor
  import chopper_pkg::*;
#(
  parameter int unsigned MONO_DEFAULT = MONO_MIN_CYCLES
) (
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               route_to_flag,
  input wire logic               bridge_a_enable_in,
  input wire logic               bridge_a_overcurrent,
  input wire logic               over_temperature,
  input wire logic [TIMER_W-1:0] bridge_a_offtime_timer,
  input wire logic               bridge_a_enable_oe,
  input wire logic               bridge_a_overcurrent_flag,
  input wire gates_t             bridge_a_gates,
  input wire logic               bridge_a_chopping
);
  logic        lo, hi, flt;
  int unsigned off_q, on_q, chop_q, mono;
  assign lo = bridge_a_gates.low_first;
  assign hi = bridge_a_gates.high_first;
  assign flt = bridge_a_overcurrent | over_temperature;
  assign mono = (bridge_a_offtime_timer == '0) ? MONO_DEFAULT
    : int'(bridge_a_offtime_timer);
  // Run lengths of the first leg and of chopping
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      off_q <= 0;
      on_q <= 0;
      chop_q <= 0;
    end else begin
      off_q <= (lo | hi) ? 0 : off_q + 1;
      on_q <= lo ? on_q + 1 : 0;
      chop_q <= bridge_a_chopping ? chop_q + 1 : 0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_enable_off_all: assert property (
    !bridge_a_enable_in |-> ##2 bridge_a_gates == 4'h0)
    else $error("gates on while disabled");
  a_fault_pulls_enable: assert property (
    flt && !route_to_flag |=> bridge_a_enable_oe)
    else $error("fault without pull-down");
  a_fault_to_flag: assert property (
    flt && route_to_flag |=> bridge_a_overcurrent_flag && !bridge_a_enable_oe)
    else $error("fault not routed to flag");
  a_no_shoot_through: assert property (
    !(hi && lo) && !(bridge_a_gates.high_second && bridge_a_gates.low_second))
    else $error("both switches of a leg on");
  a_dead_before_low: assert property (
    $rose(lo) |-> off_q >= DEAD_CYCLES)
    else $error("low switch on without dead time");
  a_dead_before_high: assert property (
    $rose(hi) |-> off_q >= DEAD_CYCLES)
    else $error("upper switch on without dead time");
  a_min_on_time: assert property (
    $fell(lo) && bridge_a_chopping |-> on_q >= MIN_ON_CYCLES)
    else $error("on time below minimum");
  a_chop_low_off: assert property (
    bridge_a_chopping |-> !lo)
    else $error("low switch on while chopping");
  a_off_interval: assert property (
    $fell(bridge_a_chopping) && bridge_a_enable_in |->
      chop_q == mono + DEAD_CYCLES)
    else $error("off interval length wrong");
  c_chop: cover property ($rose(bridge_a_chopping));
  c_pull: cover property ($rose(bridge_a_enable_oe));
  c_flag: cover property ($rose(bridge_a_overcurrent_flag));
  c_rectify: cover property ($rose(hi));
endmodule // chopper_monitor
`default_nettype wire

// >>> chopper_pkg.sv
package chopper_pkg;

  localparam int unsigned CLOCK_MHZ = 100;

  // Times in nanoseconds
  localparam int unsigned DEAD_TIME_NS   = 1000;
  localparam int unsigned BLANK_TIME_NS  = 1000;
  localparam int unsigned MIN_ON_TIME_NS = 1500;
  localparam int unsigned MIN_OFF_TIME_NS = 6600;
  localparam int unsigned MAX_OFF_TIME_NS = 6000000;

  // Least times round up
  localparam int unsigned DEAD_CYCLES =
    (DEAD_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned BLANK_CYCLES =
    (BLANK_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned MIN_ON_CYCLES =
    (MIN_ON_TIME_NS * CLOCK_MHZ + 999) / 1000;
  // Monostable part of the off time (total minus dead time)
  localparam int unsigned MONO_MIN_CYCLES =
    ((MIN_OFF_TIME_NS - DEAD_TIME_NS) * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned MONO_MAX_CYCLES =
    ((MAX_OFF_TIME_NS - DEAD_TIME_NS) / 1000) * CLOCK_MHZ;

  localparam int unsigned TIMER_W = 20;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 20'h00000;

  typedef enum logic [1:0] {
    DIR_BRAKE_LOW,
    DIR_FORWARD,
    DIR_REVERSE,
    DIR_BRAKE_HIGH
  } dir_t;

  // Gate drives of one bridge
  typedef struct packed {
    logic high_first;
    logic low_first;
    logic high_second;
    logic low_second;
  } gates_t;

  // Controller inputs of one bridge
  typedef struct packed {
    logic dir_first;
    logic dir_second;
    logic enable_in;
    logic sense_trip;
    logic fault;
  } bridge_in_t;

endpackage

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import chopper_pkg::*;
;
  logic   clock = 1'b0, rst = 1'b1, route_to_flag = 1'b0, en_a = 1'b0;
  logic   over_temperature = 1'b0, en_b = 1'b0;
  logic   bridge_a_dir_first = 1'b0, bridge_a_dir_second = 1'b0;
  logic   bridge_b_dir_first = 1'b0, bridge_b_dir_second = 1'b0;
  logic   bridge_a_overcurrent = 1'b0, bridge_b_overcurrent = 1'b0;
  logic   bridge_a_enable_in, bridge_b_enable_in, bridge_a_sense_trip;
  logic   bridge_b_sense_trip, bridge_a_enable_out, bridge_b_enable_out;
  logic   bridge_a_enable_oe, bridge_b_enable_oe, bridge_a_chopping;
  logic   bridge_b_chopping, bridge_a_overcurrent_flag;
  logic   bridge_b_overcurrent_flag;
  logic   [TIMER_W-1:0] bridge_a_offtime_timer = 20'h000C8;
  logic   [TIMER_W-1:0] bridge_b_offtime_timer = 20'h00000;
  gates_t bridge_a_gates, bridge_b_gates;
  gates_t exp_g [4] = '{4'h5, 4'h6, 4'h9, 4'hA};
  int     fails = 0, cmp_count = 0;
  always #5 clock = ~clock;
  assign bridge_a_enable_in = bridge_a_enable_oe ? bridge_a_enable_out : en_a;
  assign bridge_b_enable_in = bridge_b_enable_oe ? bridge_b_enable_out : en_b;
  bridge_offtime_current_chopper #(.MONO_DEFAULT(4)) DUT (
    .clock, .rst, .route_to_flag, .bridge_a_dir_first, .bridge_a_dir_second,
    .bridge_b_dir_first, .bridge_b_dir_second, .bridge_a_enable_in,
    .bridge_b_enable_in, .bridge_a_sense_trip, .bridge_b_sense_trip,
    .bridge_a_overcurrent, .bridge_b_overcurrent, .over_temperature,
    .bridge_a_offtime_timer, .bridge_b_offtime_timer, .bridge_a_enable_out,
    .bridge_a_enable_oe, .bridge_b_enable_out, .bridge_b_enable_oe,
    .bridge_a_overcurrent_flag, .bridge_b_overcurrent_flag, .bridge_a_gates,
    .bridge_b_gates, .bridge_a_chopping, .bridge_b_chopping);
  winding_model load_a (.clock, .rst, .gates(bridge_a_gates),
    .sense_trip(bridge_a_sense_trip));
  winding_model load_b (.clock, .rst, .gates(bridge_b_gates),
    .sense_trip(bridge_b_sense_trip));
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(20);
    check(bridge_a_gates | bridge_b_gates, 4'h0);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {bridge_a_dir_first, bridge_a_dir_second} = 2'(i);
      {bridge_b_dir_first, bridge_b_dir_second} = 2'(3 - i);
      {en_a, en_b} = 2'b11;
      cyc(50);
      check(bridge_a_gates, 4'h0);
      cyc(70);
      check(bridge_a_gates, exp_g[i]);
      check(bridge_b_gates, exp_g[3 - i]);
      {en_a, en_b} = 2'b00;
      cyc(3);
      check(bridge_a_gates | bridge_b_gates, 4'h0);
    end
    {bridge_a_dir_first, bridge_a_dir_second} = 2'b01;
    {bridge_b_dir_first, bridge_b_dir_second} = 2'b01;
    {en_a, en_b} = 2'b11;
    for (int k = 0; k < 400 && bridge_a_chopping !== 1'b1; k++) begin
      cyc(1);
    end
    cyc(1);
    check(bridge_a_gates, 4'h2);
    check(bridge_b_gates, 4'h2);
    cyc(100);
    check(bridge_a_gates, 4'hA);
    check({3'h0, bridge_b_chopping}, 4'h1);
    cyc(100);
    check(bridge_a_gates, 4'h2);
    check(bridge_b_gates, 4'h6);
    cyc(100);
    check(bridge_a_gates, 4'h6);
    check({3'h0, bridge_b_chopping}, 4'h1);
    {bridge_a_dir_first, bridge_a_dir_second} = 2'b10;
    cyc(2);
    check(bridge_a_gates, 4'h0);
    cyc(110);
    check(bridge_a_gates, 4'h9);
    {route_to_flag, bridge_a_overcurrent, bridge_b_overcurrent} = 3'b111;
    cyc(2);
    check({bridge_b_overcurrent_flag, bridge_a_overcurrent_flag,
           bridge_b_enable_oe, bridge_a_enable_oe}, 4'hC);
    {route_to_flag, bridge_a_overcurrent, bridge_b_overcurrent} = 3'b001;
    cyc(3);
    check({bridge_b_overcurrent_flag, bridge_a_overcurrent_flag,
           bridge_b_enable_oe, bridge_a_enable_oe}, 4'h2);
    {bridge_b_overcurrent, over_temperature} = 2'b01;
    cyc(3);
    check({2'h0, bridge_b_enable_oe, bridge_a_enable_oe}, 4'h3);
    check({bridge_a_enable_in, bridge_b_enable_in, bridge_a_enable_out,
           bridge_b_enable_out}, 4'h0);
    check(bridge_a_gates | bridge_b_gates, 4'h0);
    report_and_stop();
  end
  initial begin
    cyc(5000);
    fails++;
    report_and_stop();
  end
endmodule // testbench
bind bridge_offtime_current_chopper chopper_monitor #(
  .MONO_DEFAULT(MONO_DEFAULT)) mon (.clock, .rst, .route_to_flag,
  .bridge_a_enable_in, .bridge_a_overcurrent, .over_temperature,
  .bridge_a_offtime_timer, .bridge_a_enable_oe, .bridge_a_overcurrent_flag,
  .bridge_a_gates, .bridge_a_chopping);
`default_nettype wire

// >>> winding_model.sv
`timescale 1ns/1ps
`default_nettype none
module winding_model
  import chopper_pkg::*;
#(
  parameter int unsigned LIMIT = 40
) (
  input  wire logic   clock,
  input  wire logic   rst,
  input  wire gates_t gates,
  output logic        sense_trip
);
  int unsigned level_q;
  logic        drive;
  // Current rises on a driven diagonal, decays otherwise
  assign drive = (gates.low_first & gates.high_second)
    | (gates.low_second & gates.high_first);
  always_ff @(negedge clock or posedge rst) begin
    if (rst) begin
      level_q <= 0;
    end else if (drive) begin
      level_q <= level_q + 1;
    end else if (level_q != 0) begin
      level_q <= level_q - 1;
    end
  end
  assign sense_trip = (level_q > LIMIT);
endmodule // winding_model
`default_nettype wire
